// ==== hdl/empp_pkg.sv ====
package empp_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 8;
  localparam int STRAP_W    = 3;  // two frequency straps plus clock source strap
  localparam int FREQ_LO    = 0;  // frequency strap field, bits 1:0
  localparam int FREQ_HI    = 1;
  localparam int CLKSRC_BIT = 2;  // clock source strap sits on address bit 2

  // ==========================================================
  // strap encodings
  localparam logic [1:0] FREQ_24M  = 2'h0;
  localparam logic [1:0] FREQ_48M  = 2'h3;
  localparam logic       CLKSRC_XTAL = 1'h0;
  localparam logic       CLKSRC_EXT  = 1'h1;

  // ==========================================================
  // reset values of the pin side
  localparam logic [STRAP_W-1:0] PULLDOWN_RST = 3'h7;
  localparam logic [STRAP_W-1:0] STRAP_RST    = 3'h0;
  localparam logic [ADDR_W-1:0]  ADDR_RST     = 16'h0000;
  localparam logic [DATA_W-1:0]  DATA_RST     = 8'h00;

  // ==========================================================
  // strobe timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS     = 70;  // least strobe low time
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;

  // ==========================================================
  // access sequencer states
  typedef enum logic [1:0] {
    EMPP_IDLE   = 2'b00,
    EMPP_SETUP  = 2'b01,
    EMPP_STROBE = 2'b10,
    EMPP_HOLD   = 2'b11
  } empp_state_t;

endpackage

// ==== hdl/empp_strap_if.sv ====
// ==========================================================
// strap results handed from the strap catcher to the port
interface empp_strap_if;
  logic [empp_pkg::STRAP_W-1:0] strap_q;     // latched strap levels
  logic                         captured;    // straps latched, pins back on address duty
  logic [empp_pkg::STRAP_W-1:0] pulldown_en; // weak pull-down enables

  modport src (output strap_q, output captured, output pulldown_en);
  modport snk (input strap_q, input captured, input pulldown_en);
endinterface

// ==== hdl/empp_strap.sv ====
module empp_strap (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rstn,
  // strap pin levels
  input  wire logic [empp_pkg::STRAP_W-1:0]  strap_pin,
  // results
  empp_strap_if.src                          st
);

  logic [empp_pkg::STRAP_W-1:0] s1_q, s2_q, s3_q;
  logic [empp_pkg::STRAP_W-1:0] strap_q, strap_d;
  logic                         cap_q, cap_d;
  logic [empp_pkg::STRAP_W-1:0] pd_q, pd_d;

  // ==========================================================
  // pin synchroniser, unreset so it samples during chip reset
  always_ff @(posedge clk) begin
    s1_q <= strap_pin;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // ==========================================================
  // capture once after release, when stages two and three agree
  always_comb begin
    strap_d = strap_q;
    cap_d   = cap_q;
    pd_d    = pd_q;
    if (!cap_q && (s2_q == s3_q)) begin
      strap_d = s3_q;
      cap_d   = 1'b1;
      pd_d    = '0;
    end
  end

  // pull-downs on from reset until the straps are taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_q <= empp_pkg::STRAP_RST;
      cap_q   <= 1'b0;
      pd_q    <= empp_pkg::PULLDOWN_RST;
    end else begin
      strap_q <= strap_d;
      cap_q   <= cap_d;
      pd_q    <= pd_d;
    end
  end

  assign st.strap_q     = strap_q;
  assign st.captured    = cap_q;
  assign st.pulldown_en = pd_q;

endmodule // empp_strap

// ==== hdl/empp_port.sv ====
// What this block does
// - Sample strap pins during reset; latch their values when reset releases.
// - Frequency strap 00 means 24 MHz, 11 means 48 MHz; others reserved.
// - Weak pull-downs on strap pins during reset, off after straps latch.
// - After capture the strap pins become the low address bits.
// - Drive the address bus to select external memory locations.
// - Strap-one pins float while halted, wake line quiet and sleep set.
// - Strap-zero pins drive like upper address pins except during reset.
// - Write strobe goes low to write external memory.
// - Read strobe goes low to read external memory.
// - Chip enable low unless the low-power condition holds.
// - Chip enable held high throughout reset.
// - Data bus used only when internal ROM select reads zero.
// - Clock source strap: zero crystal 24 MHz, one external clock.
module empp_port (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // processor access side
  input  wire logic                         acc_req,
  input  wire logic                         acc_write,
  input  wire logic [empp_pkg::ADDR_W-1:0]  acc_addr,
  input  wire logic [empp_pkg::DATA_W-1:0]  acc_wdata,
  output logic                              acc_ready,
  output logic                              acc_done,
  output logic      [empp_pkg::DATA_W-1:0]  acc_rdata,
  // power and mode controls
  input  wire logic                         cpu_halt_flag,
  input  wire logic                         wake_interrupt_line,
  input  wire logic                         sleep_bit,
  input  wire logic                         internal_rom_select,
  // latched strap results
  output logic                              strap_valid,
  output logic                              clk_freq_48m,
  output logic                              clk_freq_reserved,
  output logic                              ext_clock_source,
  // memory pins
  output logic      [empp_pkg::ADDR_W-1:0]  mem_address_bus,
  input  wire logic [empp_pkg::STRAP_W-1:0] low_address_bits_in,
  output logic      [empp_pkg::STRAP_W-1:0] low_address_bits_oe,
  output logic      [empp_pkg::STRAP_W-1:0] strap_pulldown_en,
  input  wire logic [empp_pkg::DATA_W-1:0]  mem_data_bus_in,
  output logic      [empp_pkg::DATA_W-1:0]  mem_data_bus_out,
  output logic                              mem_data_bus_oe,
  output logic                              mem_read_strobe_n,
  output logic                              mem_write_strobe_n,
  output logic                              mem_chip_enable_n
);

  empp_strap_if st ();

  // ==========================================================
  // strap catcher
  empp_strap u_strap (
    .clk       (clk),
    .rstn      (rstn),
    .strap_pin (low_address_bits_in),
    .st        (st.src)
  );

  // ==========================================================
  // wake line and data pin synchronisers
  logic w1_q, w2_q, w3_q;
  logic wake_q, wake_d;
  logic [empp_pkg::DATA_W-1:0] d1_q, d2_q, d3_q;
  logic [empp_pkg::DATA_W-1:0] din_q, din_d;

  // a pin change counts only once stages two and three agree
  always_comb begin
    wake_d = wake_q;
    din_d  = din_q;
    if (w2_q == w3_q) begin
      wake_d = w3_q;
    end
    if (d2_q == d3_q) begin
      din_d = d3_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      w1_q   <= 1'b0;
      w2_q   <= 1'b0;
      w3_q   <= 1'b0;
      wake_q <= 1'b0;
      d1_q   <= empp_pkg::DATA_RST;
      d2_q   <= empp_pkg::DATA_RST;
      d3_q   <= empp_pkg::DATA_RST;
      din_q  <= empp_pkg::DATA_RST;
    end else begin
      w1_q   <= wake_interrupt_line;
      w2_q   <= w1_q;
      w3_q   <= w2_q;
      wake_q <= wake_d;
      d1_q   <= mem_data_bus_in;
      d2_q   <= d1_q;
      d3_q   <= d2_q;
      din_q  <= din_d;
    end
  end

  // ==========================================================
  // low-power condition
  logic low_power;
  assign low_power = cpu_halt_flag && !wake_q && sleep_bit;

  // ==========================================================
  // access sequencer
  empp_pkg::empp_state_t         state_q, state_d;
  logic [empp_pkg::CNT_W-1:0]    cnt_q, cnt_d;
  logic                          wr_q, wr_d;
  logic [empp_pkg::ADDR_W-1:0]   addr_q, addr_d;
  logic [empp_pkg::DATA_W-1:0]   wdata_q, wdata_d;
  logic [empp_pkg::DATA_W-1:0]   rdata_q, rdata_d;
  logic                          done_q, done_d;
  logic                          ready_q, ready_d;
  logic                          rd_n_q, rd_n_d;
  logic                          wr_n_q, wr_n_d;
  logic                          doe_q, doe_d;
  logic                          take;

  assign take = acc_req && ready_q;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    wr_d    = wr_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d  = 1'b0;
    case (state_q)
      empp_pkg::EMPP_IDLE: begin
        if (take) begin
          state_d = empp_pkg::EMPP_SETUP;
          wr_d    = acc_write;
          addr_d  = acc_addr;
          wdata_d = acc_wdata;
        end
      end
      empp_pkg::EMPP_SETUP: begin
        state_d = empp_pkg::EMPP_STROBE;
        cnt_d   = empp_pkg::STROBE_LAST;
      end
      empp_pkg::EMPP_STROBE: begin
        if (cnt_q == empp_pkg::CNT_ZERO) begin
          state_d = empp_pkg::EMPP_HOLD;
        end else begin
          cnt_d = cnt_q - empp_pkg::CNT_ONE;
        end
      end
      empp_pkg::EMPP_HOLD: begin
        state_d = empp_pkg::EMPP_IDLE;
        done_d  = 1'b1;
        if (!wr_q) begin
          rdata_d = din_q;
        end
      end
      default: begin
        state_d = empp_pkg::EMPP_IDLE;
      end
    endcase
    // strobes come from the next state so they leave flops cleanly
    rd_n_d  = !((state_d == empp_pkg::EMPP_STROBE) && !wr_d);
    wr_n_d  = !((state_d == empp_pkg::EMPP_STROBE) && wr_d);
    doe_d   = (state_d != empp_pkg::EMPP_IDLE) && wr_d;
    ready_d = (state_d == empp_pkg::EMPP_IDLE) && !take && st.captured
              && !low_power && !internal_rom_select;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= empp_pkg::EMPP_IDLE;
      cnt_q   <= empp_pkg::CNT_ZERO;
      wr_q    <= 1'b0;
      addr_q  <= empp_pkg::ADDR_RST;
      wdata_q <= empp_pkg::DATA_RST;
      rdata_q <= empp_pkg::DATA_RST;
      done_q  <= 1'b0;
      ready_q <= 1'b0;
      rd_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
      doe_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q  <= done_d;
      ready_q <= ready_d;
      rd_n_q  <= rd_n_d;
      wr_n_q  <= wr_n_d;
      doe_q   <= doe_d;
    end
  end

  // ==========================================================
  // chip enable and low address drive
  logic                          ce_n_q, ce_n_d;
  logic [empp_pkg::STRAP_W-1:0]  loe_q, loe_d;

  logic [empp_pkg::STRAP_W-1:0]  pin_float;

  // strap-one pins float in low power, strap-zero pins drive whenever the straps are captured
  for (genvar i = 0; i < empp_pkg::STRAP_W; i++) begin : g_low_oe
    assign pin_float[i] = st.strap_q[i] && low_power;
  end

  always_comb begin
    ce_n_d = !st.captured || low_power;
    loe_d  = {empp_pkg::STRAP_W{st.captured}} & ~pin_float;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ce_n_q <= 1'b1;
      loe_q  <= '0;
    end else begin
      ce_n_q <= ce_n_d;
      loe_q  <= loe_d;
    end
  end

  // ==========================================================
  // strap decode
  logic f48_q, f48_d, frsv_q, frsv_d, ext_q, ext_d;

  always_comb begin
    f48_d  = st.strap_q[empp_pkg::FREQ_HI:empp_pkg::FREQ_LO] == empp_pkg::FREQ_48M;
    frsv_d = st.captured
             && (st.strap_q[empp_pkg::FREQ_HI:empp_pkg::FREQ_LO] != empp_pkg::FREQ_48M)
             && (st.strap_q[empp_pkg::FREQ_HI:empp_pkg::FREQ_LO] != empp_pkg::FREQ_24M);
    ext_d  = st.strap_q[empp_pkg::CLKSRC_BIT] == empp_pkg::CLKSRC_EXT;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      f48_q  <= 1'b0;
      frsv_q <= 1'b0;
      ext_q  <= 1'b0;
    end else begin
      f48_q  <= f48_d;
      frsv_q <= frsv_d;
      ext_q  <= ext_d;
    end
  end

  // ==========================================================
  // outputs
  assign acc_ready           = ready_q;
  assign acc_done            = done_q;
  assign acc_rdata           = rdata_q;
  assign strap_valid         = st.captured;
  assign clk_freq_48m        = f48_q;
  assign clk_freq_reserved   = frsv_q;
  assign ext_clock_source    = ext_q;
  assign mem_address_bus     = addr_q;
  assign low_address_bits_oe = loe_q;
  assign strap_pulldown_en   = st.pulldown_en;
  assign mem_data_bus_out    = wdata_q;
  assign mem_data_bus_oe     = doe_q;
  assign mem_read_strobe_n   = rd_n_q;
  assign mem_write_strobe_n  = wr_n_q;
  assign mem_chip_enable_n   = ce_n_q;

endmodule // empp_port

// ==== bench/empp_port_asserts.sv ====
// ==========
// port checker: strap, chip enable, strobe and access timing
module empp_port_asserts (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rstn,
  // access side
  input wire logic                        acc_req,
  input wire logic                        acc_ready,
  input wire logic                        acc_done,
  input wire logic [empp_pkg::ADDR_W-1:0] acc_addr,
  // power, mode and strap results
  input wire logic                        cpu_halt_flag,
  input wire logic                        wake_interrupt_line,
  input wire logic                        sleep_bit,
  input wire logic                        internal_rom_select,
  input wire logic                        strap_valid,
  input wire logic                        clk_freq_48m,
  input wire logic                        clk_freq_reserved,
  input wire logic                        ext_clock_source,
  // memory pins
  input wire logic [empp_pkg::ADDR_W-1:0] mem_address_bus,
  input wire logic [2:0]                  low_address_bits_oe,
  input wire logic [2:0]                  strap_pulldown_en,
  input wire logic                        mem_read_strobe_n,
  input wire logic                        mem_write_strobe_n,
  input wire logic                        mem_chip_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // combined low-power condition as seen at the inputs
  wire lp = cpu_halt_flag && sleep_bit && !wake_interrupt_line;

  ce_reset_a: assert property (disable iff (1'b0) !rstn |-> mem_chip_enable_n)
    else $error("chip enable low during reset");
  pulldown_on_a: assert property (disable iff (1'b0) !rstn |-> strap_pulldown_en == 3'h7)
    else $error("pull-downs off during reset");
  pulldown_off_a: assert property (strap_valid |-> strap_pulldown_en == 3'h0)
    else $error("pull-downs left on after strap latch");
  strobe_excl_a: assert property (!(!mem_read_strobe_n && !mem_write_strobe_n))
    else $error("both strobes low");
  read_len_a: assert property ($fell(mem_read_strobe_n) |-> (!mem_read_strobe_n) [*7] ##1 mem_read_strobe_n)
    else $error("read strobe width wrong");
  write_len_a: assert property ($fell(mem_write_strobe_n) |-> (!mem_write_strobe_n) [*7] ##1 mem_write_strobe_n)
    else $error("write strobe width wrong");
  access_done_a: assert property (acc_req && acc_ready |-> ##[9:10] acc_done)
    else $error("access not finished in time");
  addr_out_a: assert property (acc_req && acc_ready |=> mem_address_bus == $past(acc_addr))
    else $error("address bus does not follow request");
  ce_active_a: assert property ($past(strap_valid, 2) && !$past(cpu_halt_flag) |-> !mem_chip_enable_n)
    else $error("chip enable high outside low power");
  ce_sleep_a: assert property ((strap_valid && lp) [*8] |-> mem_chip_enable_n)
    else $error("chip enable low in low power");
  strap_float_a: assert property ((strap_valid && lp) [*8] |-> !(low_address_bits_oe[2] && ext_clock_source) && !((|low_address_bits_oe[1:0]) && clk_freq_48m))
    else $error("strap-one pin driven in low power");
  strap_drive_a: assert property ($past(strap_valid, 2) && !ext_clock_source && !clk_freq_48m && !clk_freq_reserved |-> low_address_bits_oe == 3'h7)
    else $error("strap-zero pin not driven");
  rom_block_a: assert property (internal_rom_select [*2] |-> !acc_ready)
    else $error("access offered while internal rom selected");
endmodule // empp_port_asserts

bind empp_port empp_port_asserts empp_port_asserts_i (.*);

// ==== bench/empp_mem.sv ====
// ==========
// external program memory model
module empp_mem (
  // memory pins
  input  wire logic [7:0] addr_lo,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       ce_n,
  input  wire logic [7:0] din,
  output logic      [7:0] dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  // unwritten bytes hold the inverse of their index
  initial for (int i = 0; i < 256; i++) mem[i] = ~8'(i);
  // write lands as the strobe rises
  always @(posedge wr_n) if (!ce_n) mem[addr_lo] = din;
  // released bus floats up to the pull-ups
  assign dout = (!rd_n && !ce_n) ? mem[addr_lo] : 8'hFF;
endmodule // empp_mem

// ==== bench/empp_port_test.sv ====
// ==========
// bench for the external program memory port
module empp_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rstn = 1'b1, acc_req = 1'b0, acc_write, acc_ready, acc_done;
  logic [15:0] acc_addr, mem_address_bus;
  logic [7:0]  acc_wdata, acc_rdata, mem_data_bus_in, mem_data_bus_out, mem_dout;
  logic        cpu_halt_flag, wake_interrupt_line, sleep_bit, internal_rom_select;
  logic        strap_valid, clk_freq_48m, clk_freq_reserved, ext_clock_source;
  logic [2:0]  low_address_bits_in, low_address_bits_oe, strap_pulldown_en, strap_v = 3'h7;
  logic        mem_data_bus_oe, mem_read_strobe_n, mem_write_strobe_n, mem_chip_enable_n;
  int          fails = 0, cmp_count = 0, cyc = 0, seed = 32'h9d1b;
  int          model [int];
  logic [15:0] q [$];

  always #5 clk = ~clk;
  // undriven strap pins sit at the board strap level
  assign low_address_bits_in = (low_address_bits_oe & mem_address_bus[2:0])
                             | (~low_address_bits_oe & strap_v);
  assign mem_data_bus_in = mem_data_bus_oe ? mem_data_bus_out : mem_dout;

  empp_port empp_port_i (.*);
  empp_mem empp_mem_i (
    .addr_lo ({mem_address_bus[7:3], low_address_bits_in}),
    .rd_n    (mem_read_strobe_n),
    .wr_n    (mem_write_strobe_n),
    .ce_n    (mem_chip_enable_n),
    .din     (mem_data_bus_out),
    .dout    (mem_dout)
  );

  // ==========
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset(input logic [2:0] s);
    @(negedge clk);
    strap_v = s;
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    chk(mem_chip_enable_n, 1'b1);
    chk(strap_pulldown_en, 3'h7);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    int k = a[7:0];
    while (!acc_ready && n < 40) begin
      @(negedge clk);
      n++;
    end
    acc_req = 1'b1;
    acc_write = w;
    acc_addr = a;
    acc_wdata = d;
    @(negedge clk);
    acc_req = 1'b0;
    while (!acc_done && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(acc_done, 1'b1);
    chk(mem_address_bus, a);
    chk(mem_data_bus_oe, 1'b0);
    chk({mem_read_strobe_n, mem_write_strobe_n}, 2'h3);
    if (w)
      model[k] = d;
    else
      chk(acc_rdata, model.exists(k) ? model[k] : 255 - k);
  endtask

  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end

  // ==========
  // main sequence
  initial begin
    {acc_write, acc_addr, acc_wdata, cpu_halt_flag} = '0;
    {wake_interrupt_line, sleep_bit, internal_rom_select} = '0;
    // a real falling edge so the flops are reset before the first clock
    #1 rstn = 1'b0;
    // every strap code latched and decoded
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s));
      chk(strap_valid, 1'b1);
      chk(clk_freq_48m, s[1:0] == 2'h3);
      chk(clk_freq_reserved, s[1:0] == 2'h1 || s[1:0] == 2'h2);
      chk(ext_clock_source, s[2]);
      chk(strap_pulldown_en, 3'h0);
      chk(low_address_bits_oe, 3'h7);
      chk(mem_chip_enable_n, 1'b0);
      $display("strap test %0d done", s);
    end
    // random writes, then reads back to back
    for (int i = 0; i < 12; i++) begin
      q.push_back(16'($random(seed)));
      access(1'b1, q[i], 8'($random(seed)));
    end
    for (int i = 0; i < 16; i++)
      access(1'b0, i < 12 ? q[i] : 16'($random(seed)), 8'h00);
    $display("access test done");
    // low power with straps one, then wake
    {cpu_halt_flag, sleep_bit} = 2'h3;
    repeat (8) @(negedge clk);
    chk(mem_chip_enable_n, 1'b1);
    chk(low_address_bits_oe, 3'h0);
    wake_interrupt_line = 1'b1;
    repeat (8) @(negedge clk);
    chk(mem_chip_enable_n, 1'b0);
    chk(low_address_bits_oe, 3'h7);
    // mixed straps: only the strap-one pin floats
    do_reset(3'h4);
    wake_interrupt_line = 1'b0;
    repeat (8) @(negedge clk);
    chk(low_address_bits_oe, 3'h3);
    {cpu_halt_flag, sleep_bit} = 2'h0;
    $display("low power test done");
    // internal rom selected: requests ignored
    internal_rom_select = 1'b1;
    repeat (3) @(negedge clk);
    chk(acc_ready, 1'b0);
    acc_req = 1'b1;
    repeat (12) @(negedge clk);
    chk({mem_read_strobe_n, acc_done}, 2'h2);
    acc_req = 1'b0;
    internal_rom_select = 1'b0;
    access(1'b0, q[0], 8'h00);
    $display("rom select test done");
    conclude();
  end
endmodule // empp_port_test
